/* logic/pbc_defs.vh */
`ifndef PBC_DEFS_VH
`define PBC_DEFS_VH
// ==========================================
// configuration offsets
`define PBC_OFF_GEN_CTRL 8'hD4
`define PBC_OFF_ARB_CTRL 8'hDC
`define PBC_OFF_ARB_MASK 8'hDD
`define PBC_OFF_ARB_TOUT 8'hDE
// ==========================================
// field positions
`define PBC_BEACON_EN_BIT 10
`define PBC_PARK_BIT 7
`define PBC_TOUT_EN_BIT 7
`define PBC_AUTO_MASK_BIT 6
// ==========================================
// reset values
`define PBC_GEN_CTRL_RST 32'h00000000
`define PBC_ARB_CTRL_RST 8'h40
`define PBC_ARB_MASK_RST 8'h00
// ==========================================
// flow-control initial credits
`define PBC_FC_PH 8'h08
`define PBC_FC_PD 12'h080
`define PBC_FC_NPH 8'h04
`define PBC_FC_NPD 12'h004
`define PBC_FC_CPLH 8'h00
`define PBC_FC_CPLD 12'h000
// ==========================================
// message codes (upstream)
`define PBC_MSG_ASSERT_INTX 4'h0
`define PBC_MSG_DEASSERT_INTX 4'h1
`define PBC_MSG_PM_PME 4'h2
`define PBC_MSG_PME_TO_ACK 4'h3
`define PBC_MSG_ERR_COR 4'h4
`define PBC_MSG_ERR_NONFATAL 4'h5
`define PBC_MSG_ERR_FATAL 4'h6
// message codes (received)
`define PBC_RX_ASPM_NAK 4'h0
`define PBC_RX_PME_TURN_OFF 4'h1
`define PBC_RX_SLOT_PWR 4'h2
`define PBC_RX_UNLOCK 4'h3
`define PBC_RX_HOTPLUG 4'h4
`define PBC_RX_ADV_SW 4'h5
`define PBC_RX_VENDOR0 4'h6
`define PBC_RX_VENDOR1 4'h7
// ==========================================
// timing
`define PBC_CLK_HZ 200000000
`define PBC_BEACON_HZ 500000
`define PBC_BEACON_HALF ((`PBC_CLK_HZ / `PBC_BEACON_HZ) / 2)
`define PBC_GNT_TOUT_CLKS 16
`endif

/* logic/pbc_fifo.v */
`timescale 1ns/1ps
// ==========================================
// small synchronous fifo
module pbc_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire core_clk_in,
    input wire reset_in,
    input wire [WIDTH-1:0] wr_data_in,
    input wire wr_valid_in,
    output wire wr_ready_out,
    output wire [WIDTH-1:0] rd_data_out,
    output wire rd_valid_out,
    input wire rd_ready_in
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;
    assign wr_ready_out = (count != DEPTH[AW:0]);
    assign rd_valid_out = (count != {(AW+1){1'b0}});
    assign rd_data_out = mem[rd_ptr];
    assign do_wr = wr_valid_in && wr_ready_out;
    assign do_rd = rd_valid_out && rd_ready_in;
    always @(posedge core_clk_in) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr_data_in;
        end
    end
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

/* logic/pbc_bridge_ctrl.v */
`timescale 1ns/1ps
// What this block does
// R01: beacon only when control bit 10 set
// R02: in L2, secondary pme starts beacon
// R03: beacon toggles near 500 kHz, no de-emphasis
// R04: beacon runs until fundamental reset released
// R05: open-drain wake driven low requests power
// R06: advertise 8 posted header, 128 data
// R07: advertise 4 non-posted header and data
// R08: completion credits advertised zero, infinite
// R09: send interrupt, pme, ack and error messages
// R10: act on nak, turn-off, slot power messages
// R11: drop unlock/hotplug/as/vendor1; vendor0 unsupported
// R12: arbitrate six masters plus the bridge
// R13: two-tier priority at DCh, bit 7 parks
// R14: DDh mask bits block request inputs
// R15: DDh bit 7 enables 16-clock timeout flags
// R16: DDh bit 6 auto-masks silent granted devices
// R17: type 0 config stays in own space
// R18: type 1 to secondary becomes type 0
// R19: device n selects AD line 16+n
// R20: type 1 beyond secondary stays type 1
// R21: type 1 address layout, low bits 01
// R22: type 0 address: function, register, 00
// R23: upstream drives fundamental reset input
// R24: interrupt pin code A=00 through D=11
`include "pbc_defs.vh"
module pbc_bridge_ctrl (
    input wire core_clk_in,
    input wire reset_in,
    input wire perst_n_in,
    input wire link_l2_in,
    input wire sec_pme_n_in,
    input wire [7:0] cfg_addr_in,
    input wire [31:0] cfg_wdata_in,
    input wire [3:0] cfg_be_in,
    input wire cfg_wr_in,
    input wire cfg_rd_in,
    output reg [31:0] cfg_rdata_out,
    output reg cfg_rvalid_out,
    output reg beacon_out,
    output reg beacon_deemph_out,
    output reg wake_n_out,
    output reg wake_oe_out,
    output reg [7:0] fc_ph_out,
    output reg [11:0] fc_pd_out,
    output reg [7:0] fc_nph_out,
    output reg [11:0] fc_npd_out,
    output reg [7:0] fc_cplh_out,
    output reg [11:0] fc_cpld_out,
    input wire [3:0] tx_msg_in,
    input wire [1:0] tx_intx_pin_in,
    input wire tx_msg_valid_in,
    output wire tx_msg_ready_out,
    output reg [5:0] tx_msg_out,
    output reg tx_msg_valid_out,
    input wire tx_msg_ready_in,
    input wire [3:0] rx_msg_in,
    input wire rx_msg_valid_in,
    output reg aspm_nak_out,
    output reg turn_off_out,
    output reg slot_pwr_out,
    output reg rx_msg_ur_out,
    input wire [5:0] req_n_in,
    input wire frame_n_in,
    input wire bridge_req_in,
    output reg [5:0] gnt_n_out,
    output reg bridge_gnt_out,
    input wire cfg_req_valid_in,
    input wire cfg_req_type1_in,
    input wire [7:0] cfg_bus_in,
    input wire [7:0] sec_bus_in,
    input wire [4:0] cfg_dev_in,
    input wire [2:0] cfg_func_in,
    input wire [5:0] cfg_reg_in,
    output reg cfg_local_out,
    output reg cfg_fwd_valid_out,
    output reg [31:0] cfg_fwd_addr_out
);
    // ==========================================
    // pin synchronisers
    reg [1:0] perst_sync;
    reg [1:0] pme_sync;
    reg [6:0] req_sync0;
    reg [6:0] req_sync1;
    always @(posedge core_clk_in) begin
        perst_sync <= {perst_sync[0], perst_n_in};
        pme_sync <= {pme_sync[0], sec_pme_n_in};
        req_sync0 <= {frame_n_in, req_n_in};
        req_sync1 <= req_sync0;
    end
    wire perst_act = !perst_sync[1]; // R23
    wire pme_act = !pme_sync[1];
    wire [5:0] req_act = ~req_sync1[5:0];
    wire frame_act = !req_sync1[6];

    // ==========================================
    // registers
    reg [31:0] gen_ctrl;
    reg [7:0] arb_ctrl;
    reg [7:0] arb_mask;
    reg [5:0] tout_flags;
    reg [5:0] auto_mask;
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            gen_ctrl <= `PBC_GEN_CTRL_RST;
            arb_ctrl <= `PBC_ARB_CTRL_RST; // R13
            arb_mask <= `PBC_ARB_MASK_RST;
        end else if (cfg_wr_in) begin
            if (cfg_addr_in == `PBC_OFF_GEN_CTRL) begin
                if (cfg_be_in[0]) gen_ctrl[7:0] <= cfg_wdata_in[7:0];
                if (cfg_be_in[1]) gen_ctrl[15:8] <= cfg_wdata_in[15:8];
                if (cfg_be_in[2]) gen_ctrl[23:16] <= cfg_wdata_in[23:16];
                if (cfg_be_in[3]) gen_ctrl[31:24] <= cfg_wdata_in[31:24];
            end
            // DC..DE share one dword; lane 0 is DC
            if (cfg_addr_in == `PBC_OFF_ARB_CTRL) begin
                if (cfg_be_in[0]) arb_ctrl <= cfg_wdata_in[7:0];
                if (cfg_be_in[1]) arb_mask <= cfg_wdata_in[15:8];
            end
        end
    end
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            cfg_rdata_out <= 32'h00000000;
            cfg_rvalid_out <= 1'b0;
        end else begin
            cfg_rvalid_out <= cfg_rd_in;
            case (cfg_addr_in)
                `PBC_OFF_GEN_CTRL: cfg_rdata_out <= gen_ctrl;
                `PBC_OFF_ARB_CTRL: cfg_rdata_out <= {8'h00, 2'b00, tout_flags, arb_mask, arb_ctrl};
                default: cfg_rdata_out <= 32'h00000000;
            endcase
        end
    end

    // ==========================================
    // beacon and wake
    localparam HALF = `PBC_BEACON_HALF;
    reg beacon_on;
    reg [7:0] bcn_cnt;
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            beacon_on <= 1'b0;
            bcn_cnt <= 8'h00;
            beacon_out <= 1'b0;
            beacon_deemph_out <= 1'b0;
            wake_n_out <= 1'b1;
            wake_oe_out <= 1'b0;
        end else begin
            beacon_deemph_out <= 1'b0; // R03
            if (!perst_act) begin
                beacon_on <= 1'b0; // R04
            end else if (gen_ctrl[`PBC_BEACON_EN_BIT] && link_l2_in && pme_act) begin // R01 R02
                beacon_on <= 1'b1;
            end
            if (beacon_on) begin
                if (bcn_cnt == HALF[7:0] - 8'h01) begin
                    bcn_cnt <= 8'h00;
                    beacon_out <= !beacon_out; // R03
                end else begin
                    bcn_cnt <= bcn_cnt + 8'h01;
                end
            end else begin
                bcn_cnt <= 8'h00;
                beacon_out <= 1'b0;
            end
            // wake held low with the beacon; works in aux power
            wake_n_out <= 1'b0; // R05
            wake_oe_out <= beacon_on; // R05
        end
    end

    // ==========================================
    // flow-control credits
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            fc_ph_out <= `PBC_FC_PH; // R06
            fc_pd_out <= `PBC_FC_PD; // R06
            fc_nph_out <= `PBC_FC_NPH; // R07
            fc_npd_out <= `PBC_FC_NPD; // R07
            fc_cplh_out <= `PBC_FC_CPLH; // R08
            fc_cpld_out <= `PBC_FC_CPLD; // R08
        end
    end

    // ==========================================
    // upstream message queue
    wire [5:0] q_data;
    wire q_valid;
    wire q_ready = !tx_msg_valid_out || tx_msg_ready_in;
    wire msg_ok = tx_msg_in <= `PBC_MSG_ERR_FATAL; // R09
    pbc_fifo #(.WIDTH(6), .DEPTH(4), .AW(2)) u_fifo (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .wr_data_in({tx_msg_in, tx_intx_pin_in}), // R24
        .wr_valid_in(tx_msg_valid_in && msg_ok),
        .wr_ready_out(tx_msg_ready_out),
        .rd_data_out(q_data),
        .rd_valid_out(q_valid),
        .rd_ready_in(q_ready)
    );
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            tx_msg_out <= 6'h00;
            tx_msg_valid_out <= 1'b0;
        end else if (q_ready) begin
            tx_msg_valid_out <= q_valid;
            tx_msg_out <= q_data;
        end
    end

    // ==========================================
    // received messages: pulses, others dropped
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            aspm_nak_out <= 1'b0;
            turn_off_out <= 1'b0;
            slot_pwr_out <= 1'b0;
            rx_msg_ur_out <= 1'b0;
        end else begin
            aspm_nak_out <= rx_msg_valid_in && rx_msg_in == `PBC_RX_ASPM_NAK; // R10
            turn_off_out <= rx_msg_valid_in && rx_msg_in == `PBC_RX_PME_TURN_OFF; // R10
            slot_pwr_out <= rx_msg_valid_in && rx_msg_in == `PBC_RX_SLOT_PWR; // R10
            rx_msg_ur_out <= rx_msg_valid_in && rx_msg_in == `PBC_RX_VENDOR0; // R11
        end
    end

    // ==========================================
    // arbiter: bridge (index 6) high tier after reset
    localparam ARB_IDLE = 2'd0;
    localparam ARB_GNT = 2'd1;
    localparam ARB_BUSY = 2'd2;
    reg [1:0] arb_state;
    reg [2:0] owner;
    reg [4:0] wait_cnt;
    wire [5:0] eff_req = req_act & ~arb_mask[5:0] & ~auto_mask; // R14 R16
    wire [6:0] all_req = {bridge_req_in, eff_req};
    wire [6:0] hi_req = all_req & arb_ctrl[6:0]; // R13
    function [2:0] pick;
        input [6:0] v;
        integer i;
        begin
            pick = 3'd7;
            for (i = 6; i >= 0; i = i - 1) begin
                if (v[i]) pick = i[2:0];
            end
        end
    endfunction
    wire [2:0] hi_pick = pick(hi_req);
    wire [2:0] lo_pick = pick(all_req);
    wire [2:0] win = hi_pick != 3'd7 ? hi_pick : lo_pick;
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            arb_state <= ARB_IDLE;
            owner <= 3'd7;
            wait_cnt <= 5'd0;
            gnt_n_out <= 6'h3F;
            bridge_gnt_out <= 1'b0;
            tout_flags <= 6'h00;
            auto_mask <= 6'h00;
        end else begin
            if (!arb_mask[`PBC_AUTO_MASK_BIT]) auto_mask <= 6'h00; // R16
            case (arb_state)
                ARB_IDLE: begin
                    if (win != 3'd7 && !frame_act) begin // R12
                        owner <= win;
                        wait_cnt <= 5'd0;
                        arb_state <= ARB_GNT;
                        bridge_gnt_out <= win == 3'd6;
                        gnt_n_out <= ~(6'h01 << win);
                    end else if (arb_ctrl[`PBC_PARK_BIT]) begin // R13
                        bridge_gnt_out <= 1'b1;
                        gnt_n_out <= 6'h3F;
                    end else begin
                        bridge_gnt_out <= 1'b0;
                        gnt_n_out <= 6'h3F;
                    end
                end
                ARB_GNT: begin
                    if (frame_act) begin
                        arb_state <= ARB_BUSY;
                    end else if (wait_cnt == `PBC_GNT_TOUT_CLKS - 1) begin
                        // silent master: drop its grant, maybe flag it
                        if (owner != 3'd6) begin
                            if (arb_mask[`PBC_TOUT_EN_BIT]) tout_flags[owner] <= 1'b1; // R15
                            if (arb_mask[`PBC_AUTO_MASK_BIT]) auto_mask[owner] <= 1'b1; // R16
                        end
                        gnt_n_out <= 6'h3F;
                        bridge_gnt_out <= 1'b0;
                        arb_state <= ARB_IDLE;
                    end else begin
                        wait_cnt <= wait_cnt + 5'd1;
                    end
                end
                ARB_BUSY: begin
                    gnt_n_out <= 6'h3F;
                    bridge_gnt_out <= 1'b0;
                    if (!frame_act) arb_state <= ARB_IDLE;
                end
                default: arb_state <= ARB_IDLE;
            endcase
        end
    end

    // ==========================================
    // configuration translation
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            cfg_local_out <= 1'b0;
            cfg_fwd_valid_out <= 1'b0;
            cfg_fwd_addr_out <= 32'h00000000;
        end else begin
            cfg_local_out <= cfg_req_valid_in && !cfg_req_type1_in; // R17
            cfg_fwd_valid_out <= cfg_req_valid_in && cfg_req_type1_in;
            if (cfg_bus_in == sec_bus_in) begin
                cfg_fwd_addr_out <= {(cfg_dev_in[4] ? 16'h0000 : // R18 R19
                    16'h0001 << cfg_dev_in[3:0]), 5'h00, cfg_func_in, cfg_reg_in, 2'b00}; // R22
            end else begin
                cfg_fwd_addr_out <= {8'h00, cfg_bus_in, cfg_dev_in, // R20
                    cfg_func_in, cfg_reg_in, 2'b01}; // R21
            end
        end
    end
endmodule

/* tb/pbc_pci_dev_model.sv */
`timescale 1ns/1ps
// ==========================================
// secondary bus masters
module pbc_pci_dev_model (
    input wire core_clk_in,
    input wire [5:0] want_in,
    input wire [5:0] silent_in,
    input wire [5:0] gnt_n_in,
    output wire [5:0] req_n_out,
    output reg frame_n_out
);
    reg [2:0] cnt;
    assign req_n_out = ~want_in;
    initial begin
        frame_n_out = 1'b1;
        cnt = 3'h0;
    end
    // a granted master starts its frame later; a silent one never does
    always @(posedge core_clk_in) begin
        if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            frame_n_out <= (cnt == 3'h1);
        end else if ((~gnt_n_in & want_in & ~silent_in) != 6'h00) begin
            cnt <= 3'h6;
        end
    end
endmodule

/* tb/pbc_bridge_ctrl_props.sv */
`timescale 1ns/1ps
// ==========================================
// port checker
module pbc_bridge_ctrl_props (
    input logic core_clk_in,
    input logic reset_in,
    input logic perst_n_in,
    input logic wake_n_out,
    input logic wake_oe_out,
    input logic [7:0] fc_ph_out,
    input logic [11:0] fc_pd_out,
    input logic [7:0] fc_nph_out,
    input logic [11:0] fc_npd_out,
    input logic [7:0] fc_cplh_out,
    input logic [11:0] fc_cpld_out,
    input logic [5:0] gnt_n_out,
    input logic bridge_gnt_out,
    input logic cfg_req_valid_in,
    input logic cfg_req_type1_in,
    input logic [7:0] cfg_bus_in,
    input logic [7:0] sec_bus_in,
    input logic [4:0] cfg_dev_in,
    input logic [2:0] cfg_func_in,
    input logic [5:0] cfg_reg_in,
    input logic cfg_local_out,
    input logic cfg_fwd_valid_out,
    input logic [31:0] cfg_fwd_addr_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_t1_sec;
        cfg_req_valid_in && cfg_req_type1_in && cfg_bus_in == sec_bus_in;
    endsequence
    sequence s_t1_far;
        cfg_req_valid_in && cfg_req_type1_in && cfg_bus_in != sec_bus_in;
    endsequence
    a_posted_credit: assert property (fc_ph_out == 8'h08 && fc_pd_out == 12'h080)
        else $error("posted credits wrong");
    a_nonposted_credit: assert property (fc_nph_out == 8'h04 && fc_npd_out == 12'h004)
        else $error("non-posted credits wrong");
    a_cpl_credit_zero: assert property (fc_cplh_out == 8'h00 && fc_cpld_out == 12'h000)
        else $error("completion credits wrong");
    a_wake_drives_low: assert property (wake_oe_out |-> !wake_n_out)
        else $error("wake driven high");
    // two sync stages plus the beacon_on and wake_oe_out registers
    a_beacon_stops: assert property (perst_n_in [*5] |-> !wake_oe_out)
        else $error("beacon still on after reset released");
    a_one_grant: assert property ($onehot0({~gnt_n_out, bridge_gnt_out}))
        else $error("more than one grant");
    a_type0_local: assert property (cfg_req_valid_in && !cfg_req_type1_in |=>
        cfg_local_out && !cfg_fwd_valid_out) else $error("type 0 request forwarded");
    a_type1_far: assert property (s_t1_far |=> cfg_fwd_valid_out &&
        cfg_fwd_addr_out == {8'h00, $past(cfg_bus_in), $past(cfg_dev_in),
        $past(cfg_func_in), $past(cfg_reg_in), 2'b01}) else $error("type 1 address wrong");
    a_type1_sec: assert property (s_t1_sec |=> cfg_fwd_valid_out &&
        cfg_fwd_addr_out[10:0] == {$past(cfg_func_in), $past(cfg_reg_in), 2'b00})
        else $error("type 0 address wrong");
endmodule

/* tb/pbc_bridge_ctrl_tb.sv */
`timescale 1ns/1ps
// ==========================================
// bench top
module pbc_bridge_ctrl_tb;
    reg core_clk_in = 1'b0;
    reg reset_in = 1'b1;
    reg perst_n_in = 1'b1;
    reg link_l2_in = 1'b0;
    reg sec_pme_n_in = 1'b1;
    reg cfg_wr_in = 1'b0;
    reg cfg_rd_in = 1'b0;
    reg tx_msg_valid_in = 1'b0;
    reg tx_msg_ready_in = 1'b0;
    reg rx_msg_valid_in = 1'b0;
    reg bridge_req_in = 1'b0;
    reg cfg_req_valid_in = 1'b0;
    reg cfg_req_type1_in = 1'b0;
    reg [7:0] cfg_addr_in = 8'h00;
    reg [31:0] cfg_wdata_in = 32'h00000000;
    reg [3:0] cfg_be_in = 4'h0;
    reg [3:0] tx_msg_in = 4'h0;
    reg [1:0] tx_intx_pin_in = 2'h0;
    reg [3:0] rx_msg_in = 4'h0;
    reg [7:0] cfg_bus_in = 8'h00;
    reg [7:0] sec_bus_in = 8'h05;
    reg [4:0] cfg_dev_in = 5'h00;
    reg [2:0] cfg_func_in = 3'h0;
    reg [5:0] cfg_reg_in = 6'h00;
    reg [5:0] want = 6'h00;
    reg [5:0] silent = 6'h00;
    wire [31:0] cfg_rdata_out, cfg_fwd_addr_out;
    wire [7:0] fc_ph_out, fc_nph_out, fc_cplh_out;
    wire [11:0] fc_pd_out, fc_npd_out, fc_cpld_out;
    wire [5:0] tx_msg_out, gnt_n_out, req_n_in;
    wire cfg_rvalid_out, beacon_out, beacon_deemph_out, wake_n_out, wake_oe_out;
    wire tx_msg_ready_out, tx_msg_valid_out, aspm_nak_out, turn_off_out, slot_pwr_out;
    wire rx_msg_ur_out, bridge_gnt_out, cfg_local_out, cfg_fwd_valid_out, frame_n_in;
    integer fail_count = 0;
    integer n_checks = 0;
    integer i, j, k;
    reg [31:0] got;
    reg [5:0] g;
    reg [1:0] lf;
    reg r, b, refused;

    pbc_bridge_ctrl u_pbc_bridge_ctrl (.core_clk_in, .reset_in, .perst_n_in, .link_l2_in,
        .sec_pme_n_in, .cfg_addr_in, .cfg_wdata_in, .cfg_be_in, .cfg_wr_in, .cfg_rd_in,
        .cfg_rdata_out, .cfg_rvalid_out, .beacon_out, .beacon_deemph_out, .wake_n_out,
        .wake_oe_out, .fc_ph_out, .fc_pd_out, .fc_nph_out, .fc_npd_out, .fc_cplh_out,
        .fc_cpld_out, .tx_msg_in, .tx_intx_pin_in, .tx_msg_valid_in, .tx_msg_ready_out,
        .tx_msg_out, .tx_msg_valid_out, .tx_msg_ready_in, .rx_msg_in, .rx_msg_valid_in,
        .aspm_nak_out, .turn_off_out, .slot_pwr_out, .rx_msg_ur_out, .req_n_in, .frame_n_in,
        .bridge_req_in, .gnt_n_out, .bridge_gnt_out, .cfg_req_valid_in, .cfg_req_type1_in,
        .cfg_bus_in, .sec_bus_in, .cfg_dev_in, .cfg_func_in, .cfg_reg_in, .cfg_local_out,
        .cfg_fwd_valid_out, .cfg_fwd_addr_out);
    pbc_pci_dev_model u_pbc_pci_dev_model (.core_clk_in, .want_in(want), .silent_in(silent),
        .gnt_n_in(gnt_n_out), .req_n_out(req_n_in), .frame_n_out(frame_n_in));

    always #2.5 core_clk_in = ~core_clk_in;

    // ==========================================
    // tasks
    task check(input string what, input [31:0] exp, input [31:0] seen);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected %s: expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wr(input [31:0] d, input [3:0] be, input [7:0] a);
        begin
            @(posedge core_clk_in);
            cfg_addr_in <= a;
            cfg_wdata_in <= d;
            cfg_be_in <= be;
            cfg_wr_in <= 1'b1;
            @(posedge core_clk_in);
            cfg_wr_in <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        begin
            @(posedge core_clk_in);
            cfg_addr_in <= a;
            cfg_rd_in <= 1'b1;
            @(posedge core_clk_in);
            cfg_rd_in <= 1'b0;
            #1;
            check("read data", exp, cfg_rdata_out);
            check("read valid", 1, cfg_rvalid_out);
        end
    endtask
    task creq(input t1, input [7:0] bus, input [4:0] dev);
        begin
            @(posedge core_clk_in);
            cfg_req_valid_in <= 1'b1;
            cfg_req_type1_in <= t1;
            cfg_bus_in <= bus;
            cfg_dev_in <= dev;
            cfg_func_in <= dev[2:0];
            cfg_reg_in <= 6'h2A;
            @(posedge core_clk_in);
            cfg_req_valid_in <= 1'b0;
            lf = 2'b00;
            repeat (3) begin
                @(negedge core_clk_in);
                lf = lf | {cfg_local_out, cfg_fwd_valid_out};
                if (cfg_fwd_valid_out === 1'b1) got = cfg_fwd_addr_out;
            end
        end
    endtask
    task wait_gnt;
        begin
            g = 6'h00;
            k = 0;
            while (g == 6'h00 && k < 40) begin
                @(negedge core_clk_in);
                g = ~gnt_n_out;
                k = k + 1;
            end
            want <= 6'h00;
            repeat (20) @(posedge core_clk_in);
        end
    endtask
    task edge_span;
        begin
            b = beacon_out;
            k = 0;
            while (beacon_out === b && k < 300) begin
                @(negedge core_clk_in);
                k = k + 1;
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", n_checks, fail_count);
            if (fail_count == 0 && n_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    // ==========================================
    // watchdog, the whole run needs about a thousand clocks
    initial begin
        repeat (20000) @(posedge core_clk_in);
        fail_count = fail_count + 1;
        test_done;
    end

    // ==========================================
    // tests
    initial begin
        repeat (3) @(posedge core_clk_in);
        reset_in <= 1'b0;
        rd(8'hD4, 32'h00000000);
        rd(8'hDC, 32'h00000040);
        wr(32'hFFFFFFFF, 4'hF, 8'hE0);
        rd(8'hE0, 32'h00000000);
        creq(1'b0, 8'h00, 5'h02);
        check("type0 route", 2'b10, lf);
        for (i = 0; i < 18; i = i + 1) begin
            creq(1'b1, 8'h05, i[4:0]);
            check("idsel route", 2'b01, lf);
            check("idsel addr", {(i < 16) ? (16'h1 << i) : 16'h0, 5'h0, i[2:0], 8'hA8}, got);
        end
        creq(1'b1, 8'h09, 5'h13);
        check("type1 addr", {16'h0009, 5'h13, 3'h3, 8'hA9}, got);
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge core_clk_in);
            rx_msg_in <= i[3:0];
            rx_msg_valid_in <= 1'b1;
            @(posedge core_clk_in);
            rx_msg_valid_in <= 1'b0;
            got = 0;
            repeat (3) begin
                @(negedge core_clk_in);
                got = got | {aspm_nak_out, turn_off_out, slot_pwr_out, rx_msg_ur_out};
            end
            check("rx action", (i == 0) ? 8 : (i == 1) ? 4 : (i == 2) ? 2 : (i == 6), got);
        end
        refused = 1'b0;
        fork
            begin
                @(posedge core_clk_in);
                for (i = 0; i < 8; i = i + 1) begin
                    tx_msg_in <= i[3:0];
                    tx_intx_pin_in <= i[1:0];
                    tx_msg_valid_in <= 1'b1;
                    do begin
                        @(negedge core_clk_in);
                        r = tx_msg_ready_out;
                        refused = refused | !r;
                        @(posedge core_clk_in);
                    end while (r !== 1'b1);
                end
                tx_msg_valid_in <= 1'b0;
            end
            begin
                // sink stalls first so the queue has to fill
                repeat (60) @(posedge core_clk_in);
                tx_msg_ready_in <= 1'b1;
                j = 0;
                repeat (100) begin
                    @(negedge core_clk_in);
                    if (tx_msg_valid_out === 1'b1) begin
                        check("tx msg", {j[3:0], j[1:0]}, tx_msg_out);
                        j = j + 1;
                    end
                end
            end
        join
        check("tx count", 7, j);
        check("tx refused", 1, refused);
        want <= 6'h02;
        wr(32'h00000200, 4'h2, 8'hDC);
        wait_gnt;
        check("masked gnt", 6'h00, g);
        want <= 6'h02;
        wr(32'h00000000, 4'h2, 8'hDC);
        wait_gnt;
        check("unmasked gnt", 6'h02, g);
        wr(32'h00000050, 4'h1, 8'hDC);
        want <= 6'h11;
        wait_gnt;
        check("tier gnt", 6'h10, g);
        wr(32'h000000C0, 4'h1, 8'hDC);
        repeat (10) @(posedge core_clk_in);
        #1;
        check("park gnt", 1, bridge_gnt_out);
        wr(32'h00000040, 4'h1, 8'hDC);
        wr(32'h0000C000, 4'h2, 8'hDC);
        silent <= 6'h08;
        want <= 6'h08;
        wait_gnt;
        check("silent gnt", 6'h08, g);
        rd(8'hDC, 32'h0008C040);
        want <= 6'h08;
        wait_gnt;
        check("automask gnt", 6'h00, g);
        want <= 6'h08;
        wr(32'h00008000, 4'h2, 8'hDC);
        wait_gnt;
        check("unmask gnt", 6'h08, g);
        link_l2_in <= 1'b1;
        perst_n_in <= 1'b0;
        sec_pme_n_in <= 1'b0;
        repeat (20) @(posedge core_clk_in);
        #1;
        check("beacon idle", 0, wake_oe_out | beacon_out);
        sec_pme_n_in <= 1'b1;
        wr(32'h00000400, 4'hF, 8'hD4);
        sec_pme_n_in <= 1'b0;
        edge_span;
        check("wake oe", 1, wake_oe_out);
        edge_span;
        check("beacon half", 200, k);
        check("deemph", 0, beacon_deemph_out);
        perst_n_in <= 1'b1;
        repeat (10) @(posedge core_clk_in);
        #1;
        check("beacon stop", 0, {wake_oe_out, beacon_out});
        test_done;
    end
endmodule

bind pbc_bridge_ctrl pbc_bridge_ctrl_props u_pbc_bridge_ctrl_props (.core_clk_in, .reset_in,
    .perst_n_in, .wake_n_out, .wake_oe_out, .fc_ph_out, .fc_pd_out, .fc_nph_out, .fc_npd_out,
    .fc_cplh_out, .fc_cpld_out, .gnt_n_out, .bridge_gnt_out, .cfg_req_valid_in,
    .cfg_req_type1_in, .cfg_bus_in, .sec_bus_in, .cfg_dev_in, .cfg_func_in, .cfg_reg_in,
    .cfg_local_out, .cfg_fwd_valid_out, .cfg_fwd_addr_out);
